// [bench/caw_load.sv]
`timescale 1ns/1ps
// ----------------------------------------
// external load: counts high cycles and edges on one pin
// ----------------------------------------
module caw_load (
  input wire logic i_clk,
  input wire logic i_clr,
  input wire logic [2:0] i_sel,
  input wire logic [4:0] i_pin,
  output logic [15:0] o_high,
  output logic [15:0] o_edges
);
  logic last_reg;
  // pins are pure outputs, so the load only observes
  always @(posedge i_clk)
  begin
    last_reg <= i_pin[i_sel];
    if (i_clr)
    begin
      o_high <= 16'h0000;
      o_edges <= 16'h0000;
    end
    else
    begin
      o_high <= o_high + 16'(i_pin[i_sel]);
      o_edges <= o_edges + 16'(i_pin[i_sel] != last_reg);
    end
  end
endmodule

// [bench/caw_top_chk.sv]
`timescale 1ns/1ps
module caw_chk #(
  parameter NMOD = 5
) (
  input wire I_CORE_CLK,
  input wire I_RST_N,
  input wire I_PSEL,
  input wire I_PENABLE,
  input wire I_PWRITE,
  input wire [7:0] I_PADDR,
  input wire [31:0] I_PWDATA,
  input wire [31:0] O_PRDATA,
  input wire O_PREADY,
  input wire O_PSLVERR,
  input wire [NMOD-1:0] O_MODULE_OUTPUT_PIN,
  input wire O_WDT_RESET
);
  logic wd_en_reg;
  logic wd_lock_reg;
  logic wd_prev_reg;
  wire wr = I_PSEL && I_PENABLE && I_PWRITE;
  wire wd_on = wd_en_reg || wd_lock_reg;
  // ----------------------------------------
  // shadow of the watchdog state; lock only ever sets
  // ----------------------------------------
  always @(posedge I_CORE_CLK)
  begin
    if (!I_RST_N)
    begin
      wd_en_reg <= 1'b1;
      wd_lock_reg <= 1'b0;
      wd_prev_reg <= 1'b1;
    end
    else
    begin
      wd_prev_reg <= wd_on;
      if (wr && I_PADDR == 8'h04)
      begin
        wd_en_reg <= wd_lock_reg | I_PWDATA[6] | I_PWDATA[5];
        wd_lock_reg <= wd_lock_reg | I_PWDATA[5];
      end
    end
  end
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);
  property p_pulse;
    O_WDT_RESET |=> !O_WDT_RESET;
  endproperty
  a_pulse: assert property (p_pulse) else $error("reset request too long");
  property p_cause;
    O_WDT_RESET |-> wd_prev_reg;
  endproperty
  a_cause: assert property (p_cause) else $error("reset request while off");
  property p_force;
    wr && I_PADDR == 8'h00 && I_PWDATA[4] && wd_on |=> O_WDT_RESET;
  endproperty
  a_force: assert property (p_force) else $error("forced reset missing");
  property p_off;
    !wd_on && !wd_prev_reg |-> !O_WDT_RESET;
  endproperty
  a_off: assert property (p_off) else $error("reset while disabled");
  property p_quiet;
    $rose(I_RST_N) |-> !O_WDT_RESET && O_MODULE_OUTPUT_PIN == '0;
  endproperty
  a_quiet: assert property (p_quiet) else $error("outputs active after reset");
  property p_pin4;
    wd_on && wd_prev_reg |-> !O_MODULE_OUTPUT_PIN[4];
  endproperty
  a_pin4: assert property (p_pin4) else $error("module 4 pin driven in watchdog mode");
  property p_err;
    I_PSEL && I_PENABLE && I_PADDR == 8'h1C |-> O_PSLVERR;
  endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_gate;
    !I_PENABLE |-> !O_PSLVERR && O_PREADY;
  endproperty
  a_gate: assert property (p_gate) else $error("error outside access phase");
endmodule

bind caw_top caw_chk #(.NMOD(NMOD)) i_chk (.I_CORE_CLK(I_CORE_CLK), .I_RST_N(I_RST_N),
  .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
  .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
  .O_MODULE_OUTPUT_PIN(O_MODULE_OUTPUT_PIN), .O_WDT_RESET(O_WDT_RESET));

// [bench/counter_array_waveform_watchdog_bench.sv]
`timescale 1ns/1ps
module counter_array_waveform_watchdog_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic clr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic [31:0] rdata;
  logic pready;
  logic pslverr;
  logic wdrst;
  logic err;
  logic [4:0] pins;
  logic [2:0] sel = 3'h0;
  logic [15:0] hi_cnt;
  logic [15:0] edg_cnt;
  int mismatches = 0;
  int n_tests = 0;
  int cyc = 0;
  int t0;
  always #10 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  caw_top #(.NMOD(5)) i_dut (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_CPU_IDLE(1'b0), .I_TMR0_OVF(1'b0),
    .I_EXT_INPUT(1'b1), .I_EXT_OSC(1'b0), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .O_MODULE_OUTPUT_PIN(pins), .O_WDT_RESET(wdrst));
  caw_load i_load (.i_clk(clk), .i_clr(clr), .i_sel(sel), .i_pin(pins), .o_high(hi_cnt),
    .o_edges(edg_cnt));
  // ----------------------------------------
  // compare and bus tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic rng(input string nm, input int lo, input int hi, input int got);
    n_tests++;
    if (got < lo || got > hi)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    pen <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    if (n == 20)
      chk("pready", 32'h1, 32'h0);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk(nm, {24'h000000, exp}, rdata);
  endtask
  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t0 = cyc;
  endtask
  task automatic wait_wd;
    for (int n = 0; n < 4000; n++)
    begin
      @(posedge clk);
      if (wdrst === 1'b1)
        break;
    end
  endtask
  // one sample per cycle over span cycles
  task automatic measure(input logic [2:0] s, input int span);
    sel <= s;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (span + 1) @(posedge clk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_defaults;
    do_reset();
    rd("counter low", 8'h08, 8'h00);
    rd("mode", 8'h04, 8'h40);
    rd("offset", 8'h50, 8'h00);
    rd("control", 8'h00, 8'h00);
    apb(1'b0, 8'h1C, 8'h00);
    chk("unmapped", 32'h1, {31'h0, err});
    wait_wd();
    rng("default timeout", 3060, 3100, cyc - t0);
  endtask
  task automatic t_force;
    do_reset();
    wr(8'h00, 8'h10);
    @(posedge clk);
    chk("forced reset", 32'h1, {31'h0, wdrst});
  endtask
  task automatic t_lock;
    do_reset();
    wr(8'h04, 8'h60);
    wr(8'h04, 8'h08);
    rd("locked mode", 8'h04, 8'h60);
    do_reset();
    wr(8'h04, 8'h00);
    rd("disabled mode", 8'h04, 8'h00);
    for (int i = 0; i < 6; i++)
      rd_src(8'(i << 1));
    wr(8'h04, 8'h08);
    wr(8'h00, 8'h40);
  endtask
  task automatic rd_src(input logic [7:0] m);
    wr(8'h04, m);
    rd("source", 8'h04, m);
  endtask
  task automatic t_pwm8;
    wr(8'h20, 8'h42);
    wr(8'h40, 8'hC0);
    wr(8'h60, 8'hC0);
    repeat (300) @(posedge clk);
    measure(3'h0, 512);
    chk("pwm8 high", 32'd128, {16'h0, hi_cnt});
    wr(8'h40, 8'h10);
    rd("compare enable cleared", 8'h20, 8'h02);
    repeat (300) @(posedge clk);
    measure(3'h0, 512);
    chk("zero duty", 32'd0, {16'h0, hi_cnt});
    wr(8'h60, 8'hC0);
    rd("compare enable set", 8'h20, 8'h42);
  endtask
  task automatic t_freq;
    wr(8'h24, 8'h46);
    wr(8'h44, 8'h00);
    wr(8'h64, 8'h10);
    repeat (300) @(posedge clk);
    measure(3'h1, 256);
    chk("freq edges", 32'd16, {16'h0, edg_cnt});
    wr(8'h64, 8'h00);
    repeat (600) @(posedge clk);
    measure(3'h1, 1024);
    chk("freq zero edges", 32'd4, {16'h0, edg_cnt});
  endtask
  task automatic t_pwm16;
    wr(8'h28, 8'hCA);
    wr(8'h48, 8'h00);
    wr(8'h68, 8'hFF);
    wr(8'h08, 8'h00);
    wr(8'h0C, 8'hFE);
    measure(3'h2, 512);
    chk("pwm16 high", 32'd256, {16'h0, hi_cnt});
    rd("match flag", 8'h00, 8'hC4);
  endtask
  task automatic t_wd;
    int t1;
    wr(8'h0C, 8'h80);
    wr(8'h50, 8'h02);
    wr(8'h04, 8'h48);
    wr(8'h70, 8'h00);
    t1 = cyc;
    rd("update byte", 8'h70, 8'h82);
    wr(8'h0C, 8'h00);
    wait_wd();
    rng("wd timeout", 512, 772, cyc - t1);
  endtask
  task automatic final_report;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    t_defaults();
    t_force();
    t_lock();
    t_pwm8();
    t_freq();
    t_pwm16();
    t_wd();
    final_report();
  end
  initial
  begin
    repeat (40000) @(posedge clk);
    mismatches++;
    final_report();
  end
endmodule

// [design/caw_cmp.v]
`timescale 1ns/1ps
`include "caw_defs.vh"

module caw_cmp (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_step,
  input wire [15:0] i_cnt,
  input wire i_wd_mode,
  input wire i_mode_wr,
  input wire i_cpl_wr,
  input wire i_cph_wr,
  input wire [7:0] i_wdata,
  output wire [7:0] o_mode,
  output wire [7:0] o_cpl,
  output wire [7:0] o_cph,
  output wire o_pin,
  output wire o_match
);

  reg [7:0] mode_reg;
  reg [7:0] cpl_reg;
  reg [7:0] cph_reg;
  reg pin_reg;

  wire cmp_en = mode_reg[`CAW_CPM_CMPEN];
  wire pwm = mode_reg[`CAW_CPM_PWM];
  wire tgl_en = mode_reg[`CAW_CPM_TGL];
  wire wide = mode_reg[`CAW_CPM_WIDE];
  wire freq = cmp_en & tgl_en & pwm;
  wire pwm8 = cmp_en & pwm & !tgl_en & !wide;
  wire pwm16 = cmp_en & pwm & !tgl_en & wide;
  // step marks the first cycle of a new count, so a stalled counter never re-matches
  wire lo_hit = i_step & (cpl_reg == i_cnt[7:0]);
  wire wide_hit = i_step & ({cph_reg, cpl_reg} == i_cnt);
  wire wrap8 = i_step & (i_cnt[7:0] == 8'h00);
  wire wrap16 = i_step & (i_cnt == 16'h0000);

  assign o_mode = mode_reg;
  assign o_cpl = cpl_reg;
  assign o_cph = cph_reg;
  assign o_pin = pin_reg;
  assign o_match = cmp_en & mode_reg[`CAW_CPM_MATCH] & !i_wd_mode & ((freq | pwm8) ? lo_hit : wide_hit);

  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      mode_reg <= `CAW_CPM_RST;
      cpl_reg <= `CAW_CPL_RST;
      cph_reg <= `CAW_CPH_RST;
      pin_reg <= 1'b0;
    end
    else
    begin
      if (i_mode_wr && !i_wd_mode)
        mode_reg <= i_wdata;
      if (i_cpl_wr)
      begin
        cpl_reg <= i_wdata;
        mode_reg[`CAW_CPM_CMPEN] <= 1'b0;
      end
      else if (i_cph_wr && i_wd_mode)
        cph_reg <= i_cnt[15:8] + cpl_reg;
      else if (i_cph_wr)
      begin
        cph_reg <= i_wdata;
        mode_reg[`CAW_CPM_CMPEN] <= 1'b1;
      end
      else if (freq && lo_hit)
        cpl_reg <= cpl_reg + cph_reg;
      else if (pwm8 && wrap8)
        cpl_reg <= cph_reg;
      if (i_wd_mode)
        pin_reg <= 1'b0;
      else if (pwm && !cmp_en)
        pin_reg <= 1'b0;
      else if (freq && lo_hit)
        pin_reg <= ~pin_reg;
      else if ((pwm8 && lo_hit) || (pwm16 && wide_hit))
        pin_reg <= 1'b1;
      else if ((pwm8 && wrap8) || (pwm16 && wrap16))
        pin_reg <= 1'b0;
    end
  end

endmodule

// [design/caw_defs.vh]
`ifndef CAW_DEFS_VH
`define CAW_DEFS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CAW_ADR_CTL 8'h00
`define CAW_ADR_MODE 8'h04
`define CAW_ADR_CNTL 8'h08
`define CAW_ADR_CNTH 8'h0C
`define CAW_ADR_CPM 8'h20
`define CAW_ADR_CPL 8'h40
`define CAW_ADR_CPH 8'h60

// ----------------------------------------
// counter control register fields
// ----------------------------------------
`define CAW_CTL_OVF 7
`define CAW_CTL_RUN 6
`define CAW_CTL_WDEVT 4

// ----------------------------------------
// counter mode register fields
// ----------------------------------------
`define CAW_MD_IDLE 7
`define CAW_MD_WDEN 6
`define CAW_MD_WDLOCK 5
`define CAW_MD_SRC_HI 3
`define CAW_MD_SRC_LO 1
`define CAW_MD_OVFIE 0

// ----------------------------------------
// module mode register fields
// ----------------------------------------
`define CAW_CPM_WIDE 7
`define CAW_CPM_CMPEN 6
`define CAW_CPM_MATCH 3
`define CAW_CPM_TGL 2
`define CAW_CPM_PWM 1

// ----------------------------------------
// counter source codes
// ----------------------------------------
`define CAW_SRC_DIV12 3'h0
`define CAW_SRC_DIV4 3'h1
`define CAW_SRC_TMR0 3'h2
`define CAW_SRC_EXT 3'h3
`define CAW_SRC_SYS 3'h4
`define CAW_SRC_OSC8 3'h5

// ----------------------------------------
// reset values and divider counts
// ----------------------------------------
`define CAW_CPM_RST 8'h00
`define CAW_CPL_RST 8'h00
`define CAW_CPH_RST 8'h00
`define CAW_CNT_RST 16'h0000
`define CAW_SRC_RST 3'h0
`define CAW_DIV_SLOW 4'hC
`define CAW_DIV_FAST 4'h4
`define CAW_DIV_OSC 4'h8

`endif

// [design/caw_top.v]
// What this block does
// - Frequency mode: low-byte match toggles pin, then compare low gains compare high.
// - Compare high of zero acts as a 256-count half period.
// - Frequency mode needs compare, toggle and pulse enables all set.
// - 8-bit PWM: match drives pin high, low-byte overflow drives it low.
// - 8-bit PWM: low-byte wrap reloads compare low from compare high.
// - 8-bit PWM needs compare and pulse enables, wide select clear.
// - Compare low write clears compare enable; compare high write sets it.
// - Write low byte first; clearing compare enable holds PWM pin low.
// - 16-bit PWM: full match drives pin high, counter overflow drives low.
// - 16-bit PWM needs compare, pulse and wide select all set.
// - Watchdog on enable or lock uses module 4 update and offset bytes.
// - Watchdog forces counter on unless idle-suspended, freezes source, idle, counter bytes; blocks module 4 mode writes.
// - Watchdog ignores run writes for stopping; run reads only software value.
// - Update byte write loads counter high plus offset byte.
// - Reset when low byte overflows while update byte equals counter high.
// - Writing one to module 4 event flag forces watchdog reset.
// - Lock keeps watchdog on until reset; otherwise clearing enable disables.
// - Reset enables watchdog, selects divide by 12, clears low and offset.
// - Timeout is 256 times offset plus counts left to next overflow, in counter ticks.
// - Source select: /12, /4, timer 0, external falls, sysclk, osc /8.
// - Mode register writes change only the watchdog bits while the watchdog is on.
`timescale 1ns/1ps
`include "caw_defs.vh"

module caw_top #(
  parameter NMOD = 5
) (
  input wire I_CORE_CLK,
  input wire I_RST_N,
  input wire I_PSEL,
  input wire I_PENABLE,
  input wire I_PWRITE,
  input wire [7:0] I_PADDR,
  input wire [31:0] I_PWDATA,
  input wire I_CPU_IDLE,
  input wire I_TMR0_OVF,
  input wire I_EXT_INPUT,
  input wire I_EXT_OSC,
  output wire [31:0] O_PRDATA,
  output wire O_PREADY,
  output wire O_PSLVERR,
  output wire [NMOD-1:0] O_MODULE_OUTPUT_PIN,
  output wire O_WDT_RESET
);

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // returns the module index for a word in a five-word bank, or 7 if outside it
  function [2:0] caw_idx;
    input [7:0] addr;
    input [7:0] base;
    reg [7:0] off;
    begin
      off = addr - base;
      if (addr >= base && off[1:0] == 2'b00 && off[7:2] < NMOD)
        caw_idx = off[4:2];
      else
        caw_idx = 3'h7;
    end
  endfunction

  wire setup = I_PSEL & !I_PENABLE;
  wire acc = I_PSEL & I_PENABLE;
  wire wr = acc & I_PWRITE;
  wire rd_setup = setup & !I_PWRITE;
  wire [7:0] wdata = I_PWDATA[7:0];
  wire at_ctl = (I_PADDR == `CAW_ADR_CTL);
  wire at_mode = (I_PADDR == `CAW_ADR_MODE);
  wire at_cntl = (I_PADDR == `CAW_ADR_CNTL);
  wire at_cnth = (I_PADDR == `CAW_ADR_CNTH);
  wire [2:0] cpm_idx = caw_idx(I_PADDR, `CAW_ADR_CPM);
  wire [2:0] cpl_idx = caw_idx(I_PADDR, `CAW_ADR_CPL);
  wire [2:0] cph_idx = caw_idx(I_PADDR, `CAW_ADR_CPH);
  wire mapped = at_ctl | at_mode | at_cntl | at_cnth
    | (cpm_idx != 3'h7) | (cpl_idx != 3'h7) | (cph_idx != 3'h7);

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg run_reg;
  reg ovf_flag_reg;
  reg [NMOD-1:0] evt_reg;
  reg [NMOD-1:0] evt_next;
  reg idle_sus_reg;
  reg wd_en_reg;
  reg wd_lock_reg;
  reg [2:0] src_reg;
  reg ovf_ie_reg;
  reg [15:0] cnt_reg;
  reg [7:0] snap_reg;
  reg step_reg;
  reg [3:0] div_slow_reg;
  reg [3:0] div_fast_reg;
  reg [3:0] div_osc_reg;
  reg [1:0] sync1_reg;
  reg [1:0] sync2_reg;
  reg [1:0] sync3_reg;
  reg [1:0] lvl_reg;
  reg wdt_rst_reg;
  reg [31:0] prdata_reg;
  reg pslverr_reg;
  reg tick;

  wire wd_on = wd_en_reg | wd_lock_reg;
  wire [7:0] mode_bus [0:NMOD-1];
  wire [7:0] cpl_bus [0:NMOD-1];
  wire [7:0] cph_bus [0:NMOD-1];
  wire [NMOD-1:0] match_vec;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // bit 0 external count input, bit 1 external oscillator;
  // a level is taken only once stages two and three agree
  wire [1:0] agree = ~(sync2_reg ^ sync3_reg);
  wire ext_fall = agree[0] & lvl_reg[0] & !sync3_reg[0];
  wire osc_rise = agree[1] & !lvl_reg[1] & sync3_reg[1];

  always @(posedge I_CORE_CLK)
  begin
    if (!I_RST_N)
    begin
      sync1_reg <= 2'h0;
      sync2_reg <= 2'h0;
      sync3_reg <= 2'h0;
      lvl_reg <= 2'h0;
    end
    else
    begin
      sync1_reg <= {I_EXT_OSC, I_EXT_INPUT};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      // level resets low: an idle-high count pin first shows a rise, never a counted fall
      lvl_reg <= (agree & sync3_reg) | (~agree & lvl_reg);
    end
  end

  // ----------------------------------------
  // timebase
  // ----------------------------------------
  // dividers run freely so a source change never waits on a stale count
  wire slow_tc = (div_slow_reg == `CAW_DIV_SLOW - 4'h1);
  wire fast_tc = (div_fast_reg == `CAW_DIV_FAST - 4'h1);
  wire osc_tc = osc_rise & (div_osc_reg == `CAW_DIV_OSC - 4'h1);

  always @(posedge I_CORE_CLK)
  begin
    if (!I_RST_N)
    begin
      div_slow_reg <= 4'h0;
      div_fast_reg <= 4'h0;
      div_osc_reg <= 4'h0;
    end
    else
    begin
      div_slow_reg <= slow_tc ? 4'h0 : div_slow_reg + 4'h1;
      div_fast_reg <= fast_tc ? 4'h0 : div_fast_reg + 4'h1;
      // oscillator divider moves only on agreed rising edges of its pin
      if (osc_rise)
        div_osc_reg <= osc_tc ? 4'h0 : div_osc_reg + 4'h1;
    end
  end

  always @*
  begin
    case (src_reg)
      `CAW_SRC_DIV12: tick = slow_tc;
      `CAW_SRC_DIV4: tick = fast_tc;
      `CAW_SRC_TMR0: tick = I_TMR0_OVF;
      `CAW_SRC_EXT: tick = ext_fall;
      `CAW_SRC_SYS: tick = 1'b1;
      `CAW_SRC_OSC8: tick = osc_tc;
      // codes 6 and 7 are reserved and leave the counter without a clock
      default: tick = 1'b0;
    endcase
  end

  // ----------------------------------------
  // counter
  // ----------------------------------------
  // suspend in idle only when software asked for it
  wire cnt_en = (run_reg | wd_on) & !(idle_sus_reg & I_CPU_IDLE);
  wire adv = tick & cnt_en;
  wire lo_ovf = adv & (cnt_reg[7:0] == 8'hFF);
  // a match alone is harmless; the request waits for the low byte to roll over
  wire wd_hit = wd_on & lo_ovf & (cph_bus[4] == cnt_reg[15:8]);
  // forced reset shares the request flop, so it is one cycle long as well
  wire wd_force = wd_on & wr & at_ctl & wdata[`CAW_CTL_WDEVT];

  always @(posedge I_CORE_CLK)
  begin
    if (!I_RST_N)
    begin
      cnt_reg <= `CAW_CNT_RST;
      step_reg <= 1'b0;
      snap_reg <= 8'h00;
      wdt_rst_reg <= 1'b0;
    end
    else
    begin
      step_reg <= adv;
      wdt_rst_reg <= wd_hit | wd_force;
      // taken with the low byte read data, so a carry between the two reads cannot tear the pair
      if (rd_setup && at_cntl)
        snap_reg <= cnt_reg[15:8];
      // a write beats a tick in the same cycle, so software reads back what it wrote
      if (wr && at_cntl && !wd_on)
        cnt_reg[7:0] <= wdata;
      else if (wr && at_cnth && !wd_on)
        cnt_reg[15:8] <= wdata;
      else if (adv)
        cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  // ----------------------------------------
  // control and mode registers
  // ----------------------------------------
  always @*
  begin
    // a written zero clears an event flag, a written one leaves it
    evt_next = evt_reg;
    if (wr && at_ctl)
      evt_next = evt_reg & wdata[NMOD-1:0];
    // a match in the clearing cycle survives the clear
    evt_next = evt_next | match_vec;
  end

  always @(posedge I_CORE_CLK)
  begin
    if (!I_RST_N)
    begin
      run_reg <= 1'b0;
      ovf_flag_reg <= 1'b0;
      evt_reg <= {NMOD{1'b0}};
      idle_sus_reg <= 1'b0;
      wd_en_reg <= 1'b1;
      wd_lock_reg <= 1'b0;
      src_reg <= `CAW_SRC_RST;
      ovf_ie_reg <= 1'b0;
    end
    else
    begin
      evt_reg <= evt_next;
      if (adv && cnt_reg == 16'hFFFF)
        ovf_flag_reg <= 1'b1;
      else if (wr && at_ctl && !wdata[`CAW_CTL_OVF])
        ovf_flag_reg <= 1'b0;
      // the watchdog keeps the counter going itself, so run holds only what software wrote
      if (wr && at_ctl)
        run_reg <= wdata[`CAW_CTL_RUN];
      if (wr && at_mode)
      begin
        if (wd_on)
        begin
          // only the watchdog bits react; the rest stays frozen
          if (!wd_lock_reg)
            wd_en_reg <= wdata[`CAW_MD_WDEN];
          wd_lock_reg <= wd_lock_reg | wdata[`CAW_MD_WDLOCK];
        end
        else
        begin
          idle_sus_reg <= wdata[`CAW_MD_IDLE];
          wd_en_reg <= wdata[`CAW_MD_WDEN];
          wd_lock_reg <= wdata[`CAW_MD_WDLOCK];
          src_reg <= wdata[`CAW_MD_SRC_HI:`CAW_MD_SRC_LO];
          ovf_ie_reg <= wdata[`CAW_MD_OVFIE];
        end
      end
    end
  end

  // ----------------------------------------
  // compare modules
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NMOD; g = g + 1)
    begin : gen_mod
      // only module 4 can host the watchdog
      wire wd_mode = (g == 4) && wd_on;
      caw_cmp u_cmp (
        .i_clk(I_CORE_CLK),
        .i_rst_n(I_RST_N),
        .i_step(step_reg),
        .i_cnt(cnt_reg),
        .i_wd_mode(wd_mode),
        .i_mode_wr(wr && cpm_idx == g),
        .i_cpl_wr(wr && cpl_idx == g),
        .i_cph_wr(wr && cph_idx == g),
        .i_wdata(wdata),
        .o_mode(mode_bus[g]),
        .o_cpl(cpl_bus[g]),
        .o_cph(cph_bus[g]),
        .o_pin(O_MODULE_OUTPUT_PIN[g]),
        .o_match(match_vec[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // apb read path
  // ----------------------------------------
  // read data is registered in the setup cycle, so the access phase needs no wait state
  always @(posedge I_CORE_CLK)
  begin
    if (!I_RST_N)
    begin
      prdata_reg <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end
    else if (setup)
    begin
      pslverr_reg <= !mapped;
      prdata_reg <= 32'h00000000;
      if (at_ctl)
        prdata_reg[7:0] <= {ovf_flag_reg, run_reg, {(6-NMOD){1'b0}}, evt_reg};
      else if (at_mode)
        prdata_reg[7:0] <= {idle_sus_reg, wd_en_reg, wd_lock_reg, 1'b0, src_reg, ovf_ie_reg};
      else if (at_cntl)
        prdata_reg[7:0] <= cnt_reg[7:0];
      else if (at_cnth)
        prdata_reg[7:0] <= snap_reg;
      else if (cpm_idx != 3'h7)
        prdata_reg[7:0] <= mode_bus[cpm_idx];
      else if (cpl_idx != 3'h7)
        prdata_reg[7:0] <= cpl_bus[cpl_idx];
      else if (cph_idx != 3'h7)
        prdata_reg[7:0] <= cph_bus[cph_idx];
    end
  end

  assign O_PRDATA = prdata_reg;
  assign O_PREADY = 1'b1;
  // error shows only in the access phase, where the master samples it
  assign O_PSLVERR = pslverr_reg & acc;
  assign O_WDT_RESET = wdt_rst_reg;

endmodule
